// ==== pkg/chc_defines.svh ====
`ifndef CHC_DEFINES_SVH
`define CHC_DEFINES_SVH

// register byte offsets
`define CHC_OFF_CTRL 8'h00
`define CHC_OFF_CLK 8'h04
`define CHC_OFF_STAT 8'h08
`define CHC_OFF_MASK 8'h10
`define CHC_OFF_RXD 8'h28
`define CHC_OFF_TXD 8'h2c

// controller_control fields
`define CHC_CTRL_DAT_RST 0
`define CHC_CTRL_CMD_RST 1
`define CHC_CTRL_WIDE 2
`define CHC_CTRL_EDGE_LO 6
`define CHC_CTRL_EDGE_HI 7
`define CHC_CTRL_RST 8'h00
`define CHC_CTRL_BITS 8'hc7

// card_clock_control fields
`define CHC_CLK_DIV_HI 7
`define CHC_CLK_PIN_EN 8
`define CHC_CLK_RST 9'h000

// primary_event_status bit positions
`define CHC_ST_DATA_DONE 0
`define CHC_ST_BUSY_DONE 1
`define CHC_ST_RESP_DONE 2
`define CHC_ST_RD_TOUT 3
`define CHC_ST_RESP_TOUT 4
`define CHC_ST_WR_CRC 5
`define CHC_ST_RD_CRC 6
`define CHC_ST_RESP_CRC 7
`define CHC_ST_TX_RDY 9
`define CHC_ST_RX_RDY 10
`define CHC_ST_DAT3_EDGE 11
`define CHC_ST_XFER_DONE 12
`define CHC_ST_W 13
`define CHC_ST_RST 13'h0200
`define CHC_ST_BITS 13'h1eff

`endif

// ==== pkg/chc_pkg.sv ====
package chc_pkg;

   // dat3 edge detection modes, in field encoding order
   typedef enum logic [1:0] {
      CHC_EDGE_OFF,
      CHC_EDGE_RISE,
      CHC_EDGE_FALL,
      CHC_EDGE_BOTH
   } chc_edge_e;

   typedef logic [31:0] chc_word_t;
   typedef logic [12:0] chc_stat_t;

endpackage

// ==== rtl/chc_clkdiv.sv ====
`timescale 1ns/10ps
`default_nettype none

// card clock divider: f_card = f_clk / (2 * (div + 1))
module chc_clkdiv
   import chc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic [7:0] div_i,
   output logic card_clk_o,
   output logic rise_o,
   output logic fall_o
);

   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic clk_reg;
   logic clk_next;
   logic rise_reg;
   logic rise_next;
   logic fall_reg;
   logic fall_next;

   // half period is div+1 cycles; stopping parks the pin low
   always_comb begin
      cnt_next = cnt_reg;
      clk_next = clk_reg;
      rise_next = 1'b0;
      fall_next = 1'b0;
      if (!run_i) begin
         cnt_next = 8'h00;
         clk_next = 1'b0;
      end else if (cnt_reg >= div_i) begin
         // >= so a divider lowered mid-count cannot overrun
         cnt_next = 8'h00;
         clk_next = ~clk_reg;
         rise_next = ~clk_reg;
         fall_next = clk_reg;
      end else begin
         cnt_next = cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= 8'h00;
         clk_reg <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         clk_reg <= clk_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
      end
   end

   assign card_clk_o = clk_reg;
   assign rise_o = rise_reg;
   assign fall_o = fall_reg;

endmodule

`default_nettype wire

// ==== rtl/chc_top.sv ====
//
// Contract
// - two-bit field picks dat3 edge detection: off, rise, fall, both
// - width bit picks one data line or all four
// - command-path reset bit holds command logic in reset
// - data-path reset bit holds data logic in reset
// - clock pin enable: low when clear, divided clock when set
// - card clock is function clock over two times divider plus one
// - status flag rising with mask bit set raises the interrupt
// - reading the status register clears the flags returned
// - command path independent; busy-expecting command stalls data path
// - transfer-done on last byte; data-done after crc and programming
// - dat3 edge flag set on selected edge, cleared on read
// - receive-ready set on new data, cleared by reset, clear, read
// - transmit-ready set on reset, clear option, or data sent
// - separate flags for crc errors, time-outs, response and busy done
`include "chc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module chc_top
   import chc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic irq_o,
   // card pins
   input wire logic dat3_i,
   output logic card_clk_o,
   // towards command and data engines
   output logic cmd_rst_o,
   output logic dat_rst_o,
   output logic [3:0] dat_lane_en_o,
   output logic card_clk_rise_o,
   output logic card_clk_fall_o,
   output logic dat_busy_wait_o,
   output logic [31:0] tx_data_o,
   output logic tx_load_o,
   // events from command and data engines
   input wire logic cmd_issue_i,
   input wire logic cmd_data_clear_i,
   input wire logic cmd_busy_expected_i,
   input wire logic resp_crc_err_i,
   input wire logic read_crc_err_i,
   input wire logic write_crc_err_i,
   input wire logic resp_timeout_i,
   input wire logic read_timeout_i,
   input wire logic resp_done_i,
   input wire logic busy_done_i,
   input wire logic xfer_last_byte_i,
   input wire logic crc_prog_done_i,
   input wire logic rx_valid_i,
   input wire logic [31:0] rx_data_i,
   input wire logic tx_sent_i
);

   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [8:0] clk_reg;
   logic [8:0] clk_next;
   chc_stat_t mask_reg;
   chc_stat_t mask_next;
   chc_stat_t stat_reg;
   chc_stat_t stat_next;
   chc_word_t rdata_reg;
   chc_word_t rdata_next;
   chc_word_t rxd_reg;
   chc_word_t rxd_next;
   chc_word_t txd_reg;
   chc_word_t txd_next;
   logic tx_load_reg;
   logic tx_load_next;
   logic busy_wait_reg;
   logic busy_wait_next;
   logic xfer_pend_reg;
   logic xfer_pend_next;
   logic dat3_meta_reg;
   logic dat3_sync_reg;
   logic dat3_prev_reg;
   logic dat3_prev_next;
   logic cmd_rst;
   logic dat_rst;
   logic wr_ctrl;
   logic wr_clk;
   logic wr_mask;
   logic wr_txd;
   logic rd_stat;
   logic rd_rxd;
   logic dat_clear;
   logic dat3_rise;
   logic dat3_fall;
   logic dat3_hit;
   chc_edge_e edge_mode;
   chc_stat_t ev_set;
   chc_stat_t ev_clr;

   // address decode; unmapped writes are dropped
   always_comb begin
      wr_ctrl = wr_i && (addr_i == `CHC_OFF_CTRL);
      wr_clk = wr_i && (addr_i == `CHC_OFF_CLK);
      wr_mask = wr_i && (addr_i == `CHC_OFF_MASK);
      wr_txd = wr_i && (addr_i == `CHC_OFF_TXD);
      rd_stat = rd_i && (addr_i == `CHC_OFF_STAT);
      rd_rxd = rd_i && (addr_i == `CHC_OFF_RXD);
   end

   // configuration registers
   always_comb begin
      ctrl_next = ctrl_reg;
      clk_next = clk_reg;
      mask_next = mask_reg;
      if (wr_ctrl) begin
         // both path resets land in one write
         ctrl_next = wdata_i[7:0] & `CHC_CTRL_BITS;
      end
      if (wr_clk) begin
         // bits above the enable are dropped, read as zero
         clk_next = wdata_i[8:0];
      end
      if (wr_mask) begin
         mask_next = wdata_i[12:0] & `CHC_ST_BITS;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= `CHC_CTRL_RST;
         clk_reg <= `CHC_CLK_RST;
         mask_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         clk_reg <= clk_next;
         mask_reg <= mask_next;
      end
   end

   assign cmd_rst = ctrl_reg[`CHC_CTRL_CMD_RST];
   assign dat_rst = ctrl_reg[`CHC_CTRL_DAT_RST];
   assign cmd_rst_o = cmd_rst;
   assign dat_rst_o = dat_rst;
   // narrow mode leaves lines 1..3 idle
   assign dat_lane_en_o = ctrl_reg[`CHC_CTRL_WIDE] ? 4'hf : 4'h1;
   assign edge_mode = chc_edge_e'(
      ctrl_reg[`CHC_CTRL_EDGE_HI:`CHC_CTRL_EDGE_LO]);

   // card clock divider, parked low while the pin is off
   chc_clkdiv u_clkdiv (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(clk_reg[`CHC_CLK_PIN_EN]),
      .div_i(clk_reg[`CHC_CLK_DIV_HI:0]),
      .card_clk_o(card_clk_o),
      .rise_o(card_clk_rise_o),
      .fall_o(card_clk_fall_o)
   );

   // dat3 pin is asynchronous: two flops before the edge detector
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dat3_meta_reg <= 1'b0;
         dat3_sync_reg <= 1'b0;
      end else begin
         dat3_meta_reg <= dat3_i;
         dat3_sync_reg <= dat3_meta_reg;
      end
   end

   // edge detection on the synchronised level
   always_comb begin
      dat3_prev_next = dat3_sync_reg;
      dat3_rise = dat3_sync_reg && !dat3_prev_reg;
      dat3_fall = !dat3_sync_reg && dat3_prev_reg;
      case (edge_mode)
         CHC_EDGE_OFF: dat3_hit = 1'b0;
         CHC_EDGE_RISE: dat3_hit = dat3_rise;
         CHC_EDGE_FALL: dat3_hit = dat3_fall;
         CHC_EDGE_BOTH: dat3_hit = dat3_rise || dat3_fall;
         default: dat3_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dat3_prev_reg <= 1'b0;
      end else begin
         dat3_prev_reg <= dat3_prev_next;
      end
   end

   // a data-clear command or data reset clears receive-ready and sets transmit-ready
   assign dat_clear = dat_rst || (cmd_issue_i && cmd_data_clear_i && !cmd_rst);

   // busy wait and transfer tracking in the data path
   always_comb begin
      busy_wait_next = busy_wait_reg;
      xfer_pend_next = xfer_pend_reg;
      if (dat_rst) begin
         busy_wait_next = 1'b0;
         xfer_pend_next = 1'b0;
      end else begin
         // commands run alone; only a busy-expecting one stalls data
         if (busy_done_i && !cmd_rst) begin
            busy_wait_next = 1'b0;
         end
         if (cmd_issue_i && cmd_busy_expected_i && !cmd_rst) begin
            busy_wait_next = 1'b1;
         end
         // crc done closes the transfer, even beside its last byte
         if (crc_prog_done_i) begin
            xfer_pend_next = 1'b0;
         end else if (xfer_last_byte_i) begin
            xfer_pend_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_wait_reg <= 1'b0;
         xfer_pend_reg <= 1'b0;
      end else begin
         busy_wait_reg <= busy_wait_next;
         xfer_pend_reg <= xfer_pend_next;
      end
   end

   assign dat_busy_wait_o = busy_wait_reg;

   // event sources; engines held in reset raise nothing
   always_comb begin
      ev_set = '0;
      ev_set[`CHC_ST_RESP_CRC] = resp_crc_err_i && !cmd_rst;
      ev_set[`CHC_ST_RESP_TOUT] = resp_timeout_i && !cmd_rst;
      ev_set[`CHC_ST_RESP_DONE] = resp_done_i && !cmd_rst;
      ev_set[`CHC_ST_BUSY_DONE] = busy_done_i && !cmd_rst;
      ev_set[`CHC_ST_RD_CRC] = read_crc_err_i && !dat_rst;
      ev_set[`CHC_ST_WR_CRC] = write_crc_err_i && !dat_rst;
      ev_set[`CHC_ST_RD_TOUT] = read_timeout_i && !dat_rst;
      ev_set[`CHC_ST_XFER_DONE] = xfer_last_byte_i && !dat_rst;
      ev_set[`CHC_ST_DATA_DONE] = crc_prog_done_i && !dat_rst &&
         (xfer_pend_reg || xfer_last_byte_i);
      ev_set[`CHC_ST_DAT3_EDGE] = dat3_hit;
      ev_set[`CHC_ST_RX_RDY] = rx_valid_i && !dat_rst;
      ev_set[`CHC_ST_TX_RDY] = dat_clear ||
         (tx_sent_i && !dat_rst);
   end

   // clear sources: status read, plus functional clears of ready flags
   always_comb begin
      ev_clr = '0;
      if (rd_stat) begin
         ev_clr = `CHC_ST_BITS;
      end
      if (dat_clear || rd_rxd) begin
         ev_clr[`CHC_ST_RX_RDY] = 1'b1;
      end
      if (wr_txd) begin
         ev_clr[`CHC_ST_TX_RDY] = 1'b1;
      end
      // software may also drop flags by writing ones
      if (wr_i && (addr_i == `CHC_OFF_STAT)) begin
         ev_clr = ev_clr | (wdata_i[12:0] & `CHC_ST_BITS);
      end
   end

   // set beats clear so an event on the read cycle survives
   always_comb begin
      stat_next = ((stat_reg & ~ev_clr) | ev_set) & `CHC_ST_BITS;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_reg <= `CHC_ST_RST;
      end else begin
         stat_reg <= stat_next;
      end
   end

   // level interrupt; a flag that rises while enabled asserts it
   assign irq_o = |(stat_reg & mask_reg);

   // data holding registers
   always_comb begin
      rxd_next = rxd_reg;
      txd_next = txd_reg;
      tx_load_next = 1'b0;
      if (dat_rst) begin
         rxd_next = '0;
      end else if (rx_valid_i) begin
         rxd_next = rx_data_i;
      end
      // transmit writes are dropped while the data path sits in reset
      if (wr_txd && !dat_rst) begin
         txd_next = wdata_i;
         tx_load_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rxd_reg <= '0;
         txd_reg <= '0;
         tx_load_reg <= 1'b0;
      end else begin
         rxd_reg <= rxd_next;
         txd_reg <= txd_next;
         tx_load_reg <= tx_load_next;
      end
   end

   assign tx_data_o = txd_reg;
   assign tx_load_o = tx_load_reg;

   // read mux, answer in the cycle after the strobe; unmapped reads 0
   always_comb begin
      rdata_next = '0;
      if (rd_i) begin
         case (addr_i)
            `CHC_OFF_CTRL: rdata_next = {24'h000000, ctrl_reg};
            `CHC_OFF_CLK: rdata_next = {23'h000000, clk_reg};
            `CHC_OFF_STAT: rdata_next = {19'h00000, stat_reg};
            `CHC_OFF_MASK: rdata_next = {19'h00000, mask_reg};
            `CHC_OFF_RXD: rdata_next = rxd_reg;
            `CHC_OFF_TXD: rdata_next = txd_reg;
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;

endmodule

`default_nettype wire

// ==== testbench/chc_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none

// port-level checks beside the card host controller
module chc_top_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic irq_o,
   input wire logic card_clk_o,
   input wire logic card_clk_rise_o,
   input wire logic card_clk_fall_o,
   input wire logic cmd_rst_o,
   input wire logic dat_rst_o,
   input wire logic [3:0] dat_lane_en_o,
   input wire logic dat_busy_wait_o,
   input wire logic [31:0] tx_data_o,
   input wire logic tx_load_o,
   input wire logic cmd_issue_i,
   input wire logic cmd_busy_expected_i,
   input wire logic busy_done_i
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // two status reads, no busy release between them
   sequence quiet_reads;
      rd_i && addr_i == 8'h08 && !busy_done_i ##1 !busy_done_i
         ##1 rd_i && addr_i == 8'h08;
   endsequence

   rdata_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data not zero outside a read");
   clk_rise_a: assert property ($rose(card_clk_o) |-> card_clk_rise_o)
      else $error("card clock rose without rise pulse");
   clk_fall_a: assert property (card_clk_fall_o |-> $fell(card_clk_o))
      else $error("fall pulse without card clock falling");
   wide_bus_a: assert property (wr_i && addr_i == 8'h00 && wdata_i[2]
      |=> dat_lane_en_o == 4'hf) else $error("wide bus not four lanes");
   narrow_bus_a: assert property (wr_i && addr_i == 8'h00 && !wdata_i[2]
      |=> dat_lane_en_o == 4'h1) else $error("narrow bus not lane 0");
   path_reset_a: assert property (wr_i && addr_i == 8'h00
      && wdata_i[1:0] == 2'b11 |=> cmd_rst_o && dat_rst_o)
      else $error("path resets not taken");
   busy_set_a: assert property (cmd_issue_i && cmd_busy_expected_i
      && !cmd_rst_o && !dat_rst_o |=> dat_busy_wait_o)
      else $error("busy command did not stall data path");
   busy_release_a: assert property (dat_busy_wait_o && busy_done_i
      && !cmd_issue_i && !cmd_rst_o |=> !dat_busy_wait_o)
      else $error("data path kept waiting after busy release");
   irq_read_a: assert property (irq_o && rd_i && addr_i == 8'h08
      |=> rdata_o != 32'h0) else $error("irq high with empty status");
   stat_clear_a: assert property (quiet_reads |=> !rdata_o[1])
      else $error("status bit survived a read");
   tx_load_a: assert property (wr_i && addr_i == 8'h2c && !dat_rst_o
      |=> tx_load_o && tx_data_o == $past(wdata_i))
      else $error("transmit word not loaded");
   tx_block_a: assert property (wr_i && addr_i == 8'h2c && dat_rst_o
      |=> !tx_load_o) else $error("transmit load during data reset");

   cover property (dat_busy_wait_o && busy_done_i);
   cover property (irq_o && rd_i && addr_i == 8'h08);
   cover property (card_clk_rise_o);
endmodule

bind chc_top chc_top_checker i_chc_top_checker (.clk_i, .rst_n_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .card_clk_o,
   .card_clk_rise_o, .card_clk_fall_o, .cmd_rst_o, .dat_rst_o,
   .dat_lane_en_o, .dat_busy_wait_o, .tx_data_o, .tx_load_o,
   .cmd_issue_i, .cmd_busy_expected_i, .busy_done_i);

`default_nettype wire

// ==== testbench/chc_card_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// card-side engines: request bits become one-cycle event pulses
module chc_card_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [12:0] go_i,
   input wire logic busy_wait_i,
   input wire logic [3:0] busy_len_i,
   input wire logic [31:0] rx_val_i,
   output logic [12:0] ev_o,
   output logic [31:0] rx_word_o
);
   logic [3:0] cnt;

   // a card holds busy for busy_len_i + 1 cycles before releasing it
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ev_o <= 13'h0;
         cnt <= 4'h0;
         rx_word_o <= 32'h0;
      end else begin
         ev_o <= go_i;
         cnt <= busy_wait_i ? cnt + 4'h1 : 4'h0;
         if (busy_wait_i && cnt == busy_len_i) begin
            ev_o[1] <= 1'b1;
         end
         // word is only meaningful with its valid pulse
         rx_word_o <= go_i[10] ? rx_val_i : ~rx_word_o;
      end
   end
endmodule

`default_nettype wire

// ==== testbench/test_chc_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module test_chc_top;
   import chc_pkg::*;
   logic clk_i, rst_n_i, wr, rd, dat3, iss, data_clear_option, bexp, irq, cclk;
   logic rise, fall, bwait;
   logic [7:0] addr;
   logic [3:0] blen;
   logic [12:0] go, ev;
   chc_word_t wdata, rdata, rxv, rxw;
   logic [7:0] dv [4] = '{8'h00, 8'h03, 8'hff, 8'h11};
   logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h0c};
   int mismatches, n_compared, ctl, ck, st, msk, pend, n, h;

   chc_top i_chc_top (.clk_i, .rst_n_i, .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .dat3_i(dat3),
      .card_clk_o(cclk), .cmd_rst_o(), .dat_rst_o(), .dat_lane_en_o(),
      .card_clk_rise_o(rise), .card_clk_fall_o(fall),
      .dat_busy_wait_o(bwait), .tx_data_o(), .tx_load_o(),
      .cmd_issue_i(iss), .cmd_data_clear_i(data_clear_option),
      .cmd_busy_expected_i(bexp), .resp_crc_err_i(ev[7]),
      .read_crc_err_i(ev[6]), .write_crc_err_i(ev[5]),
      .resp_timeout_i(ev[4]), .read_timeout_i(ev[3]),
      .resp_done_i(ev[2]), .busy_done_i(ev[1]), .xfer_last_byte_i(ev[12]),
      .crc_prog_done_i(ev[0]), .rx_valid_i(ev[10]), .rx_data_i(rxw),
      .tx_sent_i(ev[9]));
   chc_card_model i_chc_card_model (.clk_i, .rst_n_i, .go_i(go),
      .busy_wait_i(bwait), .busy_len_i(blen), .rx_val_i(rxv), .ev_o(ev),
      .rx_word_o(rxw));

   // 25 MHz function clock
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (mismatches == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // a bound that ran out is a failure and ends the run
   task automatic over(int c, int lim);
      if (c >= lim) begin
         mismatches++;
         end_of_test();
      end
   endtask

   // one bus access, model update, irq check; two cycles each
   task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
      logic [31:0] e;
      case (a)
         8'h00: e = ctl;
         8'h04: e = ck;
         8'h08: e = st;
         8'h10: e = msk;
         8'h28: e = rxv;
         default: e = 32'h0;
      endcase
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk_i);
      wr <= 1'b0;
      rd <= 1'b0;
      if (w && a == 8'h00) begin
         ctl = d & 32'hc7;
         if (d[0]) pend = 0;
      end
      if (w && a == 8'h04) ck = d & 32'h1ff;
      if (w && a == 8'h08) st = st & ~d;
      if (w && a == 8'h10) msk = d & 32'h1eff;
      if (w && a == 8'h2c && !ctl[0]) st = st & ~32'h200;
      if (!w && a == 8'h08) st = 0;
      if (!w && a == 8'h28) st = st & ~32'h400;
      @(negedge clk_i);
      if (!w) chk("rdata", rdata, e);
      chk("irq", irq, |(st & msk));
      // data reset reaches the flags one cycle after the write lands
      if (w && a == 8'h00 && d[0]) st = st & ~32'h400 | 32'h200;
      @(posedge clk_i);
   endtask

   // events pass the partner, then land in the status model
   task automatic fire(logic [12:0] b);
      go <= b;
      @(posedge clk_i);
      go <= 13'h0;
      repeat (2) @(posedge clk_i);
      if (ctl[1]) b = b & ~13'h0096;
      if (ctl[0]) b = b & ~13'h1669;
      pend = pend | b[12];
      if (b[0] && pend) st = st | 1;
      if (b[0]) pend = 0;
      st = st | (b & 13'h16fe);
      @(negedge clk_i);
      chk("irq", irq, |(st & msk));
      @(posedge clk_i);
   endtask

   task automatic cmd(logic c, logic b);
      iss <= 1'b1;
      data_clear_option <= c;
      bexp <= b;
      @(posedge clk_i);
      iss <= 1'b0;
      @(posedge clk_i);
      if (c && !ctl[1]) st = st & ~32'h400 | 32'h200;
   endtask

   initial begin
      {wr, rd, dat3, iss, data_clear_option, bexp} = 6'h0;
      {addr, wdata, go, blen, rxv} = '0;
      {mismatches, n_compared, ctl, ck, msk, pend} = '0;
      st = 32'h200;
      rst_n_i = 1'b0;
      void'($urandom(43363));
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      chk("card_clk", cclk, 1'b0);
      @(posedge clk_i);
      foreach (ra[i]) acc(1'b0, ra[i], 32'h0);
      // register round trips with junk in reserved bits
      repeat (4) begin
         acc(1'b1, 8'h00, $urandom & 32'hfffffffc);
         acc(1'b0, 8'h00, 32'h0);
         acc(1'b1, 8'h10, $urandom);
         acc(1'b0, 8'h10, 32'h0);
      end
      acc(1'b1, 8'h10, 32'h1eff);
      // one receive word: the register keeps the last valid one
      rxv = $urandom;
      for (int i = 1; i < 13; i++) begin
         fire(13'h1 << i);
         acc(1'b0, 8'h08, 32'h0);
      end
      fire(13'h0001);
      fire(13'h1001);
      acc(1'b0, 8'h08, 32'h0);
      acc(1'b0, 8'h28, 32'h0);
      fire(13'h00fe);
      acc(1'b1, 8'h08, 32'h0f);
      acc(1'b0, 8'h08, 32'h0);
      acc(1'b1, 8'h2c, $urandom);
      fire(13'h0400);
      cmd(1'b1, 1'b0);
      acc(1'b0, 8'h08, 32'h0);
      blen = 4'h2 + 4'($urandom % 6);
      cmd(1'b0, 1'b1);
      @(negedge clk_i);
      chk("busy_wait", bwait, 1'b1);
      for (n = 0; bwait === 1'b1 && n < 40; n++) @(negedge clk_i);
      over(n, 40);
      st = st | 2;
      @(posedge clk_i);
      acc(1'b0, 8'h08, 32'h0);
      acc(1'b0, 8'h08, 32'h0);
      // event landing in the clearing read cycle
      acc(1'b1, 8'h10, 32'h0);
      go <= 13'h4;
      @(posedge clk_i);
      go <= 13'h0;
      acc(1'b0, 8'h08, 32'h0);
      st = 4;
      acc(1'b0, 8'h08, 32'h0);
      acc(1'b1, 8'h10, 32'h1eff);
      acc(1'b1, 8'h00, 32'h3);
      acc(1'b1, 8'h2c, $urandom);
      fire(13'h16ff);
      acc(1'b1, 8'h00, 32'h0);
      acc(1'b0, 8'h08, 32'h0);
      for (int m = 0; m < 4; m++) begin
         acc(1'b1, 8'h00, m << 6);
         dat3 <= 1'b1;
         repeat (6) @(posedge clk_i);
         if (m[0]) st = st | 32'h800;
         acc(1'b0, 8'h08, 32'h0);
         dat3 <= 1'b0;
         repeat (6) @(posedge clk_i);
         if (m[1]) st = st | 32'h800;
         acc(1'b0, 8'h08, 32'h0);
      end
      // card clock: full period and high phase per divider
      foreach (dv[i]) begin
         acc(1'b1, 8'h04, 32'h100 | dv[i]);
         // look only at negedges, never in the edge that launches rise
         n = 0;
         do begin
            @(negedge clk_i);
            n++;
         end while (rise !== 1'b1 && n < 600);
         over(n, 600);
         n = 0;
         do begin
            @(negedge clk_i);
            n++;
            if (fall === 1'b1) h = n;
         end while (rise !== 1'b1 && n < 600);
         chk("period", n, 2 * (dv[i] + 1));
         chk("high", h, dv[i] + 1);
         @(posedge clk_i);
      end
      acc(1'b1, 8'h04, 32'h0ff);
      repeat (30) begin
         @(negedge clk_i);
         chk("card_clk", cclk, 1'b0);
      end
      end_of_test();
   end
endmodule

`default_nettype wire
